// file: core/homing_sequencer.sv
// homing sequencer for dog and index-pulse reference methods, axi4-lite control
// Summary of operation
// - method -41 is -9 reversed
// - method -42 is -10 reversed
// - method -43 is -11 reversed
// - start on dog: back off, then search
// - dog methods reverse at stroke end
// - no stroke reversal with software limit
// - dogless stroke end stops with alarm
`timescale 1ns/1ns
module homing_sequencer (
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic [7:0]  I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [7:0]  I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	input  wire logic        I_DOG,
	input  wire logic        I_STROKE_FWD,
	input  wire logic        I_STROKE_REV,
	input  wire logic        I_ZPHASE,
	input  wire logic        I_ENC_STEP,
	input  wire logic        I_AT_SPEED,
	input  wire logic        I_STOPPED,
	output logic             O_RUN,
	output logic             O_DIR_REV,
	output logic             O_CREEP,
	output logic             O_TARGET_REACHED,
	output logic             O_HOMED,
	output logic             O_HOMING_INCOMPLETE_ALARM
);

	logic        awready_reg, awready_next, wready_reg, wready_next;
	logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        start_reg, start_next, softlim_reg, softlim_next, start_prev_reg;
	logic [7:0]  method_reg, method_next;
	logic [23:0] shift_reg, shift_next;
	logic        wr_fire, rd_fire, start_rise;

	homing_pkg::homing_state_e state_reg, state_next;
	homing_pkg::homing_kind_e  kind_reg, kind_next;
	logic rev_sel_reg, rev_sel_next, seen_dog_reg, seen_dog_next;
	logic run_reg, run_next, dir_reg, dir_next, creep_reg, creep_next;
	logic homed_reg, homed_next, target_reg, target_next, alarm_reg, alarm_next;
	logic stroke_hit, cnt_load, cnt_done, method_ok;

	assign wr_fire    = awready_reg & I_AWVALID & I_WVALID;
	assign rd_fire    = arready_reg & I_ARVALID;
	assign start_rise = start_reg & ~start_prev_reg;

	// bus channels: address and data are taken together, one answer outstanding
	always_comb begin
		awready_next = I_AWVALID & I_WVALID & ~awready_reg & ~bvalid_reg;
		wready_next  = I_AWVALID & I_WVALID & ~awready_reg & ~bvalid_reg;
		arready_next = I_ARVALID & ~arready_reg & ~rvalid_reg;
		bvalid_next  = bvalid_reg & ~I_BREADY;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg & ~I_RREADY;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next  = (I_AWADDR == homing_pkg::OFS_CTRL || I_AWADDR == homing_pkg::OFS_METHOD
				|| I_AWADDR == homing_pkg::OFS_SHIFT) ? homing_pkg::RESP_OKAY
				: homing_pkg::RESP_SLVERR;
		end
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next  = homing_pkg::RESP_OKAY;
			case (I_ARADDR)
				homing_pkg::OFS_CTRL: begin
					rdata_next = '0;
					rdata_next[homing_pkg::CTRL_START_BIT]   = start_reg;
					rdata_next[homing_pkg::CTRL_SOFTLIM_BIT] = softlim_reg;
				end
				homing_pkg::OFS_METHOD: rdata_next = {24'h000000, method_reg};
				homing_pkg::OFS_SHIFT:  rdata_next = {8'h00, shift_reg};
				homing_pkg::OFS_STATUS: begin
					rdata_next = '0;
					rdata_next[homing_pkg::STAT_ALARM_BIT]  = alarm_reg;
					rdata_next[homing_pkg::STAT_TARGET_BIT] = target_reg;
					rdata_next[homing_pkg::STAT_HOMED_BIT]  = homed_reg;
					rdata_next[homing_pkg::STAT_STATE_LSB+:4] = state_reg;
				end
				default: begin
					rdata_next = '0;
					rresp_next = homing_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// register writes honour byte strobes; the status word is read only
	always_comb begin
		start_next   = start_reg;
		softlim_next = softlim_reg;
		method_next  = method_reg;
		shift_next   = shift_reg;
		if (wr_fire && I_WSTRB[0]) begin
			if (I_AWADDR == homing_pkg::OFS_CTRL) begin
				start_next   = I_WDATA[homing_pkg::CTRL_START_BIT];
				softlim_next = I_WDATA[homing_pkg::CTRL_SOFTLIM_BIT];
			end
			if (I_AWADDR == homing_pkg::OFS_METHOD)
				method_next = I_WDATA[7:0];
		end
		if (wr_fire && I_AWADDR == homing_pkg::OFS_SHIFT) begin
			for (int b = 0; b < 3; b++) begin
				if (I_WSTRB[b])
					shift_next[8*b+:8] = I_WDATA[8*b+:8];
			end
		end
	end

	// bus and register state
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			awready_reg    <= 1'b0;
			wready_reg     <= 1'b0;
			arready_reg    <= 1'b0;
			bvalid_reg     <= 1'b0;
			rvalid_reg     <= 1'b0;
			bresp_reg      <= homing_pkg::RESP_OKAY;
			rresp_reg      <= homing_pkg::RESP_OKAY;
			rdata_reg      <= '0;
			start_reg      <= 1'b0;
			start_prev_reg <= 1'b0;
			softlim_reg    <= 1'b0;
			method_reg     <= homing_pkg::METHOD_RST;
			shift_reg      <= homing_pkg::SHIFT_RST;
		end else begin
			awready_reg    <= awready_next;
			wready_reg     <= wready_next;
			arready_reg    <= arready_next;
			bvalid_reg     <= bvalid_next;
			rvalid_reg     <= rvalid_next;
			bresp_reg      <= bresp_next;
			rresp_reg      <= rresp_next;
			rdata_reg      <= rdata_next;
			start_reg      <= start_next;
			start_prev_reg <= start_reg;
			softlim_reg    <= softlim_next;
			method_reg     <= method_next;
			shift_reg      <= shift_next;
		end
	end

	// stroke end in the direction of travel only; the far one is harmless
	assign stroke_hit = run_reg & (dir_reg ? I_STROKE_REV : I_STROKE_FWD);
	assign method_ok  = (method_reg == homing_pkg::METHOD_DOG_LASTZ)
		|| (method_reg == homing_pkg::METHOD_DOG_FRONT)
		|| (method_reg == homing_pkg::METHOD_DOGLESS_Z)
		|| (method_reg == homing_pkg::METHOD_DOG_LASTZ_REV)
		|| (method_reg == homing_pkg::METHOD_DOG_FRONT_REV)
		|| (method_reg == homing_pkg::METHOD_DOGLESS_Z_REV);

	// homing sequence; outputs are computed from the next state so they align
	always_comb begin
		state_next    = state_reg;
		kind_next     = kind_reg;
		rev_sel_next  = rev_sel_reg;
		seen_dog_next = seen_dog_reg;
		run_next      = run_reg;
		dir_next      = dir_reg;
		creep_next    = creep_reg;
		homed_next    = homed_reg;
		target_next   = target_reg;
		alarm_next    = alarm_reg;
		cnt_load      = 1'b0;
		case (state_reg)
			homing_pkg::ST_IDLE, homing_pkg::ST_DONE, homing_pkg::ST_FAULT: begin
				if (start_rise) begin
					homed_next  = 1'b0;
					target_next = 1'b0;
					alarm_next  = ~method_ok;
					creep_next  = 1'b0;
					// reversed variants share the sequence of their base method
					rev_sel_next = (method_reg[5] == 1'b0);
					case (method_reg[1:0])
						2'h3:    kind_next = homing_pkg::KIND_LASTZ;
						2'h2:    kind_next = homing_pkg::KIND_FRONT;
						default: kind_next = homing_pkg::KIND_DOGLESS;
					endcase
					if (!method_ok) begin
						state_next = homing_pkg::ST_FAULT;
					end else if (I_DOG && method_reg[1]) begin
						state_next = homing_pkg::ST_BACKOFF;
						run_next   = 1'b1;
						dir_next   = method_reg[5];
					end else begin
						state_next = homing_pkg::ST_SEARCH;
						run_next   = 1'b1;
						dir_next   = ~method_reg[5];
					end
				end
			end
			homing_pkg::ST_BACKOFF: begin
				if (stroke_hit) begin
					state_next = homing_pkg::ST_FAULT;
					run_next   = 1'b0;
					alarm_next = 1'b1;
				end else if (!I_DOG) begin
					state_next = homing_pkg::ST_BACKSTOP;
					run_next   = 1'b0;
				end
			end
			homing_pkg::ST_BACKSTOP: begin
				if (I_STOPPED) begin
					state_next = homing_pkg::ST_SEARCH;
					run_next   = 1'b1;
					dir_next   = rev_sel_reg;
				end
			end
			homing_pkg::ST_SEARCH: begin
				if (stroke_hit) begin
					if (kind_reg == homing_pkg::KIND_DOGLESS || softlim_reg) begin
						state_next = homing_pkg::ST_FAULT;
						run_next   = 1'b0;
						alarm_next = 1'b1;
					end else begin
						state_next    = homing_pkg::ST_REVERSE;
						dir_next      = ~dir_reg;
						seen_dog_next = 1'b0;
					end
				end else if (kind_reg == homing_pkg::KIND_DOGLESS ? I_ZPHASE : I_DOG) begin
					state_next = homing_pkg::ST_DECEL;
					creep_next = 1'b1;
				end
			end
			homing_pkg::ST_REVERSE: begin
				if (I_DOG)
					seen_dog_next = 1'b1;
				if (stroke_hit) begin
					state_next = homing_pkg::ST_FAULT;
					run_next   = 1'b0;
					alarm_next = 1'b1;
				end else if (seen_dog_reg && !I_DOG) begin
					state_next = homing_pkg::ST_BACKSTOP;
					run_next   = 1'b0;
				end
			end
			homing_pkg::ST_DECEL: begin
				if (kind_reg == homing_pkg::KIND_LASTZ && !I_DOG && !I_AT_SPEED) begin
					state_next = homing_pkg::ST_FAULT;
					run_next   = 1'b0;
					alarm_next = 1'b1;
				end else if (I_AT_SPEED) begin
					if (kind_reg == homing_pkg::KIND_LASTZ) begin
						state_next = homing_pkg::ST_ZWAIT;
					end else begin
						state_next = homing_pkg::ST_SHIFT;
						cnt_load   = 1'b1;
					end
				end
			end
			homing_pkg::ST_ZWAIT: begin
				if (I_ZPHASE) begin
					state_next = homing_pkg::ST_SHIFT;
					cnt_load   = 1'b1;
				end
			end
			homing_pkg::ST_SHIFT: begin
				if (cnt_done) begin
					state_next = homing_pkg::ST_FINISH;
					run_next   = 1'b0;
				end
			end
			homing_pkg::ST_FINISH: begin
				if (I_STOPPED) begin
					state_next  = homing_pkg::ST_DONE;
					homed_next  = 1'b1;
					target_next = 1'b1;
				end
			end
			default: begin
				state_next = homing_pkg::ST_IDLE;
				run_next   = 1'b0;
			end
		endcase
		// dropping the start bit mid-sequence stops the motor; home stays unset except in ST_FINISH when I_STOPPED comes in the same cycle
		if (!start_reg && state_reg != homing_pkg::ST_IDLE && state_reg != homing_pkg::ST_DONE
			&& state_reg != homing_pkg::ST_FAULT) begin
			state_next = homing_pkg::ST_IDLE;
			run_next   = 1'b0;
			cnt_load   = 1'b0;
		end
	end

	// sequencer state
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state_reg    <= homing_pkg::ST_IDLE;
			kind_reg     <= homing_pkg::KIND_LASTZ;
			rev_sel_reg  <= 1'b0;
			seen_dog_reg <= 1'b0;
			run_reg      <= 1'b0;
			dir_reg      <= 1'b0;
			creep_reg    <= 1'b0;
			homed_reg    <= 1'b0;
			target_reg   <= 1'b0;
			alarm_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			kind_reg     <= kind_next;
			rev_sel_reg  <= rev_sel_next;
			seen_dog_reg <= seen_dog_next;
			run_reg      <= run_next;
			dir_reg      <= dir_next;
			creep_reg    <= creep_next;
			homed_reg    <= homed_next;
			target_reg   <= target_next;
			alarm_reg    <= alarm_next;
		end
	end

	// shift distance is counted in encoder steps while creeping
	shift_counter u_shift_counter (
		.i_clk        (I_CLK),
		.i_reset_n    (I_RESET_N),
		.i_load       (cnt_load),
		.i_load_value (shift_reg),
		.i_step       (I_ENC_STEP && state_reg == homing_pkg::ST_SHIFT),
		.o_done       (cnt_done)
	);

	// every port below is a flip-flop output
	assign O_AWREADY                 = awready_reg;
	assign O_WREADY                  = wready_reg;
	assign O_BVALID                  = bvalid_reg;
	assign O_BRESP                   = bresp_reg;
	assign O_ARREADY                 = arready_reg;
	assign O_RVALID                  = rvalid_reg;
	assign O_RRESP                   = rresp_reg;
	assign O_RDATA                   = rdata_reg;
	assign O_RUN                     = run_reg;
	assign O_DIR_REV                 = dir_reg;
	assign O_CREEP                   = creep_reg;
	assign O_TARGET_REACHED          = target_reg;
	assign O_HOMED                   = homed_reg;
	assign O_HOMING_INCOMPLETE_ALARM = alarm_reg;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);

	a_rev_lastz: assert property ((state_reg == homing_pkg::ST_SEARCH && method_reg ==
		homing_pkg::METHOD_DOG_LASTZ_REV && $past(state_reg) != homing_pkg::ST_SEARCH) |-> O_DIR_REV)
		else $error("reversed last-index method searches forward");
	a_rev_front: assert property ((state_reg == homing_pkg::ST_SEARCH && method_reg ==
		homing_pkg::METHOD_DOG_FRONT && $past(state_reg) != homing_pkg::ST_SEARCH) |-> !O_DIR_REV)
		else $error("front-end method searches in reverse");
	a_rev_dogless: assert property ((state_reg == homing_pkg::ST_SEARCH && kind_reg ==
		homing_pkg::KIND_DOGLESS) |-> O_DIR_REV == rev_sel_reg)
		else $error("dogless search direction wrong");
	a_dog_overrun: assert property ((state_reg == homing_pkg::ST_DECEL && start_reg &&
		kind_reg == homing_pkg::KIND_LASTZ && !I_DOG && !I_AT_SPEED)
		|=> O_HOMING_INCOMPLETE_ALARM && !O_RUN) else $error("dog overrun not flagged");
	a_start_on_dog: assert property ((start_rise && method_ok && I_DOG && method_reg[1]
		&& (state_reg == homing_pkg::ST_IDLE || state_reg == homing_pkg::ST_DONE
		|| state_reg == homing_pkg::ST_FAULT)) |=> state_reg == homing_pkg::ST_BACKOFF
		&& O_DIR_REV != rev_sel_reg) else $error("no back-off when starting on dog");
	a_stroke_reverse: assert property ((state_reg == homing_pkg::ST_SEARCH && start_reg &&
		stroke_hit && kind_reg != homing_pkg::KIND_DOGLESS && !softlim_reg)
		|=> state_reg == homing_pkg::ST_REVERSE && O_DIR_REV != $past(O_DIR_REV))
		else $error("no reversal at stroke end");
	a_softlim_noturn: assert property ((state_reg == homing_pkg::ST_SEARCH && start_reg &&
		stroke_hit && softlim_reg) |=> state_reg == homing_pkg::ST_FAULT)
		else $error("reversal offered with software limit");
	a_dogless_stroke: assert property ((state_reg == homing_pkg::ST_SEARCH && start_reg &&
		stroke_hit && kind_reg == homing_pkg::KIND_DOGLESS)
		|=> O_HOMING_INCOMPLETE_ALARM && !O_RUN) else $error("dogless stroke end not alarmed");
	a_homed_at_end: assert property ($rose(O_HOMED) |-> O_TARGET_REACHED
		&& $past(state_reg) == homing_pkg::ST_FINISH && !O_RUN)
		else $error("home declared outside finish");
	a_creep_shift: assert property ((state_reg == homing_pkg::ST_SHIFT) |-> O_CREEP && O_RUN)
		else $error("shift not travelled at creep");

endmodule // homing_sequencer

// file: core/homing_pkg.sv
// constants, field positions and state codes for the homing sequencer
package homing_pkg;

	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_METHOD = 8'h04;
	localparam logic [7:0] OFS_SHIFT  = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;

	// control word fields
	localparam int unsigned CTRL_SOFTLIM_BIT = 0;
	localparam int unsigned CTRL_START_BIT   = 4;

	// status word fields
	localparam int unsigned STAT_ALARM_BIT  = 0;
	localparam int unsigned STAT_TARGET_BIT = 10;
	localparam int unsigned STAT_HOMED_BIT  = 12;
	localparam int unsigned STAT_STATE_LSB  = 16;

	// homing method codes, two's complement in eight bits
	localparam logic [7:0] METHOD_DOG_LASTZ     = 8'hf7;
	localparam logic [7:0] METHOD_DOG_FRONT     = 8'hf6;
	localparam logic [7:0] METHOD_DOGLESS_Z     = 8'hf5;
	localparam logic [7:0] METHOD_DOG_LASTZ_REV = 8'hd7;
	localparam logic [7:0] METHOD_DOG_FRONT_REV = 8'hd6;
	localparam logic [7:0] METHOD_DOGLESS_Z_REV = 8'hd5;

	// reset values
	localparam logic [7:0]  METHOD_RST = 8'hf7;
	localparam int unsigned SHIFT_W    = 24;
	localparam logic [23:0] SHIFT_RST  = 24'h000000;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		KIND_LASTZ   = 2'h0,
		KIND_FRONT   = 2'h1,
		KIND_DOGLESS = 2'h2
	} homing_kind_e;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_BACKOFF  = 4'h1,
		ST_BACKSTOP = 4'h2,
		ST_SEARCH   = 4'h3,
		ST_REVERSE  = 4'h4,
		ST_DECEL    = 4'h5,
		ST_ZWAIT    = 4'h6,
		ST_SHIFT    = 4'h7,
		ST_FINISH   = 4'h8,
		ST_DONE     = 4'h9,
		ST_FAULT    = 4'ha
	} homing_state_e;

endpackage

// file: core/shift_counter.sv
// down-counter for the home position shift distance in encoder steps
`timescale 1ns/1ns
module shift_counter (
	input  wire logic                         i_clk,
	input  wire logic                         i_reset_n,
	input  wire logic                         i_load,
	input  wire logic [homing_pkg::SHIFT_W-1:0] i_load_value,
	input  wire logic                         i_step,
	output logic                              o_done
);

	logic [homing_pkg::SHIFT_W-1:0] count_reg;
	logic [homing_pkg::SHIFT_W-1:0] count_next;
	logic                           done_reg;
	logic                           done_next;

	// load wins over a step in the same cycle; done is registered
	always_comb begin
		count_next = count_reg;
		done_next  = done_reg;
		if (i_load) begin
			count_next = i_load_value;
			done_next  = (i_load_value == '0);
		end else if (i_step && !done_reg) begin
			count_next = count_reg - 1'b1;
			done_next  = (count_reg == {{(homing_pkg::SHIFT_W-1){1'b0}}, 1'b1});
		end
	end

	// count state
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_reg <= '0;
			done_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			done_reg  <= done_next;
		end
	end

	assign o_done = done_reg;

endmodule // shift_counter

// file: verif/homing_motor_model.sv
// motor, encoder, dog, stroke and index sensors seen by the homing sequencer
`timescale 1ns/1ns
module homing_motor_model #(
	parameter int STROKE = 200
) (
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	input  wire logic               i_run,
	input  wire logic               i_dir_rev,
	input  wire logic               i_creep,
	input  wire logic               i_place,
	input  wire logic signed [31:0] i_place_pos,
	input  wire logic signed [31:0] i_dog_lo,
	input  wire logic signed [31:0] i_dog_hi,
	input  wire logic signed [31:0] i_zper,
	input  wire logic signed [31:0] i_lag,
	output logic                    o_dog,
	output logic                    o_stroke_fwd,
	output logic                    o_stroke_rev,
	output logic                    o_zphase,
	output logic                    o_enc_step,
	output logic                    o_at_speed,
	output logic                    o_stopped
);
	int pos_reg;
	int coast_reg;
	int creep_reg;
	// shaft keeps turning for lag cycles after run drops, as a real deceleration does
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pos_reg   <= 0;
			coast_reg <= 0;
			creep_reg <= 0;
		end else if (i_place) begin
			pos_reg   <= i_place_pos;
			coast_reg <= 0;
			creep_reg <= 0;
		end else begin
			if (o_enc_step)
				pos_reg <= i_dir_rev ? pos_reg - 1 : pos_reg + 1;
			coast_reg <= i_run ? i_lag : (coast_reg > 0 ? coast_reg - 1 : 0);
			creep_reg <= (i_run && i_creep) ? creep_reg + 1 : 0;
		end
	end
	// creep comes two cycles past the lag so the deceleration window is never empty
	assign o_at_speed   = (creep_reg >= i_lag + 2);
	assign o_enc_step   = (i_run || coast_reg > 0) && !i_place;
	assign o_stopped    = !i_run && coast_reg == 0;
	assign o_dog        = pos_reg >= i_dog_lo && pos_reg <= i_dog_hi;
	assign o_stroke_fwd = pos_reg >= STROKE;
	assign o_stroke_rev = pos_reg <= -STROKE;
	assign o_zphase     = i_zper > 0 && pos_reg % i_zper == 0;
endmodule // homing_motor_model

// file: verif/homing_sequencer_tb_top.sv
// self-checking bench for the homing sequencer with a motor model
`timescale 1ns/1ns
module homing_sequencer_tb_top;
	logic        I_CLK = 0, I_RESET_N = 0, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
	logic        I_ARVALID = 0, I_RREADY = 0, place = 0;
	logic [7:0]  I_AWADDR = 8'h00, I_ARADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h00000000;
	logic [3:0]  I_WSTRB = 4'h0;
	logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, I_DOG, I_ZPHASE;
	logic        I_STROKE_FWD, I_STROKE_REV, I_ENC_STEP, I_AT_SPEED, I_STOPPED;
	logic        O_RUN, O_DIR_REV, O_CREEP, O_TARGET_REACHED, O_HOMED, O_HOMING_INCOMPLETE_ALARM;
	logic [1:0]  O_BRESP, O_RRESP;
	logic [31:0] O_RDATA;
	int          place_pos = 0, dog_lo = 40, dog_hi = 76, zper = 8, lag = 1;
	int          error_cnt = 0, check_count = 0, steps = 0, n = 0;
	logic        ran = 0, dir0 = 0, flip = 0, early = 0;
	logic [31:0] seed = 32'heb022a46;
	logic [7:0]  mt [6] = '{homing_pkg::METHOD_DOG_LASTZ, homing_pkg::METHOD_DOG_FRONT,
		homing_pkg::METHOD_DOGLESS_Z, homing_pkg::METHOD_DOG_LASTZ_REV,
		homing_pkg::METHOD_DOG_FRONT_REV, homing_pkg::METHOD_DOGLESS_Z_REV};

	homing_sequencer homing_sequencer_inst (.*);

	homing_motor_model homing_motor_model_inst (
		.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_run(O_RUN), .i_dir_rev(O_DIR_REV),
		.i_creep(O_CREEP), .i_place(place), .i_place_pos(place_pos), .i_dog_lo(dog_lo),
		.i_dog_hi(dog_hi), .i_zper(zper), .i_lag(lag), .o_dog(I_DOG),
		.o_stroke_fwd(I_STROKE_FWD), .o_stroke_rev(I_STROKE_REV), .o_zphase(I_ZPHASE),
		.o_enc_step(I_ENC_STEP), .o_at_speed(I_AT_SPEED), .o_stopped(I_STOPPED));

	always #10 I_CLK = ~I_CLK;

	// motion monitor: first direction, reversals, creep steps, homed while moving
	always @(posedge I_CLK) begin
		if (O_RUN === 1'b1 && !ran) begin
			ran = 1;
			dir0 = O_DIR_REV;
		end
		if (O_RUN === 1'b1 && O_DIR_REV !== dir0) flip = 1;
		if (O_HOMED === 1'b1 && O_RUN !== 1'b0) early = 1;
		if (I_ENC_STEP && O_RUN && O_CREEP && I_AT_SPEED) steps++;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic conclude();
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one write; address and data released each when taken, bready held until bvalid
	// ready lines stay high between calls, so the next call never lowers and raises them at once
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic e);
		I_AWADDR <= a;
		I_WDATA <= d;
		I_WSTRB <= 4'hf;
		I_AWVALID <= 1;
		I_WVALID <= 1;
		I_BREADY <= 1;
		do begin
			@(posedge I_CLK);
			chk(O_WREADY === O_AWREADY, "wready apart from awready");
			if (O_AWREADY === 1'b1) I_AWVALID <= 0;
			if (O_WREADY === 1'b1) I_WVALID <= 0;
		end while (O_BVALID !== 1'b1);
		chk(O_BRESP === (e ? homing_pkg::RESP_SLVERR : homing_pkg::RESP_OKAY), "bresp");
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic e);
		I_ARADDR <= a;
		I_ARVALID <= 1;
		I_RREADY <= 1;
		do begin
			@(posedge I_CLK);
			if (O_ARREADY === 1'b1) I_ARVALID <= 0;
		end while (O_RVALID !== 1'b1);
		chk(O_RDATA === d
			&& O_RRESP === (e ? homing_pkg::RESP_SLVERR : homing_pkg::RESP_OKAY), "read");
	endtask

	// reversed codes mirror the geometry so one expectation serves both directions
	task automatic run_home(input logic [7:0] m, input logic [31:0] ctl, input int st,
			input int dh, input int zp, input logic alm, input logic d0);
		logic       rev;
		logic [2:0] sh;
		rev = m[5] === 1'b0;
		sh = 3'(rnd());
		lag <= int'(rnd() % 4) + 1;
		place_pos <= rev ? -st : st;
		dog_lo <= rev ? -dh : 40;
		dog_hi <= rev ? -40 : dh;
		zper <= zp;
		place <= 1;
		@(posedge I_CLK);
		place <= 0;
		axw(homing_pkg::OFS_METHOD, {24'h000000, m}, 0);
		axw(homing_pkg::OFS_SHIFT, {29'h00000000, sh}, 0);
		ran = 0;
		flip = 0;
		early = 0;
		steps = 0;
		axw(homing_pkg::OFS_CTRL, ctl | 32'h00000010, 0);
		// the start edge lands one cycle after the write answer; status is stale until then
		@(posedge I_CLK);
		chk(O_HOMED === 1'b0 && O_TARGET_REACHED === 1'b0, "status kept at start");
		n = 0;
		while (O_HOMED !== 1'b1 && O_HOMING_INCOMPLETE_ALARM !== 1'b1 && n < 4000) begin
			@(posedge I_CLK);
			n++;
		end
		chk(n < 4000 && O_HOMING_INCOMPLETE_ALARM === alm, "alarm state");
		chk(O_HOMED === !alm && O_TARGET_REACHED === !alm, "homed state");
		chk(O_RUN === 1'b0 && !early, "motor not stopped");
		if (!alm) chk(dir0 === (d0 ^ rev), "start direction");
		if (!alm && m[3:0] == 4'h6) chk(steps >= sh && steps <= sh + 3, "shift");
		axr(homing_pkg::OFS_STATUS, alm ? 32'h000a0001 : 32'h00091400, 0);
		axw(homing_pkg::OFS_CTRL, 32'h00000000, 0);
	endtask

	initial begin
		repeat (16) @(posedge I_CLK);
		I_RESET_N <= 1;
		@(posedge I_CLK);
		axr(homing_pkg::OFS_METHOD, 32'h000000f7, 0);
		axr(homing_pkg::OFS_SHIFT, 32'h00000000, 0);
		axr(homing_pkg::OFS_CTRL, 32'h00000000, 0);
		axw(homing_pkg::OFS_STATUS, 32'hffffffff, 1);
		axw(8'h1c, 32'h00000001, 1);
		axr(8'h10, 32'h00000000, 1);
		axr(homing_pkg::OFS_STATUS, 32'h00000000, 0);
		// dogless runs start half a turn back from the index pulse
		for (int i = 0; i < 6; i++)
			run_home(mt[i], 0, mt[i][3:0] == 4'h5 ? -4 : 0, 76, 8, 0, 0);
		run_home(homing_pkg::METHOD_DOG_FRONT, 0, 50, 76, 8, 0, 1);
		run_home(homing_pkg::METHOD_DOG_LASTZ_REV, 0, 50, 76, 8, 0, 1);
		run_home(homing_pkg::METHOD_DOG_FRONT_REV, 0, 150, 76, 8, 0, 0);
		chk(flip === 1'b1, "no turn at stroke end");
		run_home(homing_pkg::METHOD_DOG_LASTZ, 1, 150, 76, 8, 1, 0);
		run_home(homing_pkg::METHOD_DOG_LASTZ, 0, 0, 41, 8, 1, 0);
		run_home(homing_pkg::METHOD_DOGLESS_Z, 0, 190, 76, 1000, 1, 0);
		run_home(homing_pkg::METHOD_DOGLESS_Z_REV, 0, 190, 76, 1000, 1, 0);
		// clearing the start bit mid-run must stop the motor without homing;
		// the shaft is first put clear of both stroke ends so the run really starts
		place_pos <= 100;
		place <= 1;
		@(posedge I_CLK);
		place <= 0;
		axw(homing_pkg::OFS_CTRL, 32'h00000010, 0);
		@(posedge I_CLK);
		chk(O_RUN === 1'b1, "no start before abort");
		axw(homing_pkg::OFS_CTRL, 32'h00000000, 0);
		repeat (3) @(posedge I_CLK);
		chk(O_RUN === 1'b0 && O_HOMED === 1'b0
			&& O_HOMING_INCOMPLETE_ALARM === 1'b0, "abort");
		run_home(8'h00, 0, 0, 76, 8, 1, 0);
		chk(ran === 1'b0, "moved on bad code");
		conclude();
	end

	// watchdog sized well above fourteen homing runs
	initial begin
		repeat (90000) @(posedge I_CLK);
		error_cnt++;
		conclude();
	end
endmodule // homing_sequencer_tb_top
